// [rtl/bridge_gpio_pkg.sv]
// Shared constants for the bridge pin and idle command block
`default_nettype none
package bridge_gpio_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned    NUM_LINES        = 4;
  localparam int unsigned    BYTE_BITS        = 8;
  localparam int unsigned    ADDR_BITS        = 7;
  // Arbitrary default bus address
  localparam logic [6:0]     SLAVE_ADDR_DEF   = 7'h2A;

  // ****************************************
  // Function codes
  // ****************************************
  localparam logic [7:0]     FUNC_IDLE        = 8'hF2;
  localparam logic [7:0]     FUNC_PIN_WRITE   = 8'hF4;
  localparam logic [7:0]     FUNC_PIN_READ    = 8'hF5;
  localparam logic [7:0]     FUNC_PIN_ENABLE  = 8'hF6;
  localparam logic [7:0]     FUNC_PIN_CONFIG  = 8'hF7;

  // ****************************************
  // Output type codes
  // ****************************************
  localparam logic [1:0]     TYPE_QUASI       = 2'h0;
  localparam logic [1:0]     TYPE_PUSH_PULL   = 2'h1;
  localparam logic [1:0]     TYPE_INPUT_ONLY  = 2'h2;
  localparam logic [1:0]     TYPE_OPEN_DRAIN  = 2'h3;
  localparam int unsigned    TYPE_BITS        = 2;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [3:0]     LATCH_RESET      = 4'h0;
  localparam logic [3:0]     GP_EN_RESET      = 4'h0;
  localparam logic [7:0]     TYPE_RESET       = 8'h00;
  localparam logic [7:0]     SAMPLE_RESET     = 8'h00;
  localparam logic [3:0]     SAMPLE_PAD       = 4'h0;
  localparam logic [1:0]     STRONG_PU_CYCLES = 2'h2;
  localparam logic [3:0]     BIT_LAST         = 4'h8;
  localparam logic [3:0]     RD_LAST          = 4'h7;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_ADDR_ACK,
    BUS_WR_BYTE,
    BUS_WR_ACK,
    BUS_RD_BYTE,
    BUS_RD_ACK
  } bus_state_e;
endpackage
`default_nettype wire

// [rtl/bus_edge_detect.sv]
// Start, stop and clock edge detector for the two-wire bus
`default_nettype none
module bus_edge_detect (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_seen,
  output logic      stop_seen
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // Data moving while clock is high marks frame edges
  assign scl_rise   = scl_i & ~scl_q;
  assign scl_fall   = ~scl_i & scl_q;
  assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_seen  = scl_i & scl_q & ~sda_q & sda_i;
endmodule
`default_nettype wire

// [rtl/select_pin_driver.sv]
// Driver control for one select line used as select or general pin
`default_nettype none
module select_pin_driver
  import bridge_gpio_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       gp_en,
  input  wire logic       latch,
  input  wire logic [1:0] out_type,
  input  wire logic       pin_in,
  input  wire logic       select_n,
  output logic            pin_out,
  output logic            pin_oe,
  output logic            strong_pu,
  output logic            weak_pu,
  output logic            very_weak_pu
);
  logic       latch_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       quasi;

  assign quasi = gp_en && (out_type == TYPE_QUASI);

  // Strong pull-up burst on latch rising edge
  always_comb begin
    cnt_d = cnt_q;
    if (quasi && latch && !latch_q) begin
      cnt_d = STRONG_PU_CYCLES;
    end else if (!quasi || !latch) begin
      cnt_d = 2'h0;
    end else if (cnt_q != 2'h0) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      latch_q <= 1'b0;
      cnt_q   <= 2'h0;
    end else begin
      latch_q <= latch;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_out      <= 1'b1;
      pin_oe       <= 1'b1;
      strong_pu    <= 1'b0;
      weak_pu      <= 1'b0;
      very_weak_pu <= 1'b0;
    end else if (!gp_en) begin
      pin_out      <= select_n;
      pin_oe       <= 1'b1;
      strong_pu    <= 1'b0;
      weak_pu      <= 1'b0;
      very_weak_pu <= 1'b0;
    end else begin
      case (out_type)
        TYPE_QUASI: begin
          strong_pu    <= (cnt_d != 2'h0);
          very_weak_pu <= latch;
          weak_pu      <= latch && pin_in;
          pin_out      <= (cnt_d != 2'h0);
          pin_oe       <= !latch || (cnt_d != 2'h0);
        end
        TYPE_PUSH_PULL: begin
          strong_pu    <= latch;
          weak_pu      <= 1'b0;
          very_weak_pu <= 1'b0;
          pin_out      <= latch;
          pin_oe       <= 1'b1;
        end
        TYPE_OPEN_DRAIN: begin
          strong_pu    <= 1'b0;
          weak_pu      <= 1'b0;
          very_weak_pu <= 1'b0;
          pin_out      <= 1'b0;
          pin_oe       <= !latch;
        end
        default: begin
          strong_pu    <= 1'b0;
          weak_pu      <= 1'b0;
          very_weak_pu <= 1'b0;
          pin_out      <= 1'b0;
          pin_oe       <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_strong_burst_two: assert property (@(posedge core_clk) disable iff (!rst_n)
    (quasi && latch && !latch_q) ##1 (quasi && latch) [*2] |-> $past(strong_pu) && strong_pu ##1 !strong_pu)
    else $error("strong pull-up burst not two cycles");
  a_quasi_low_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
    quasi && !latch |=> pin_oe && !pin_out && !very_weak_pu)
    else $error("quasi line with latch low not driven low");
  a_weak_pull_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    quasi |=> weak_pu == ($past(latch) && $past(pin_in)))
    else $error("weak pull-up does not follow latch and pin");
  a_open_drain_pull: assert property (@(posedge core_clk) disable iff (!rst_n)
    gp_en && out_type == TYPE_OPEN_DRAIN |=> !strong_pu && !weak_pu && pin_oe == !$past(latch))
    else $error("open-drain line misdriven");
  a_push_pull_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
    gp_en && out_type == TYPE_PUSH_PULL |=> pin_oe && pin_out == $past(latch) && strong_pu == $past(latch))
    else $error("push-pull line misdriven");
endmodule
`default_nettype wire

// [rtl/bridge_gpio_idle.sv]
// Pin command and idle command handling behind the two-wire slave port
`default_nettype none
// Behaviour
// - Write with idle function code enters low-power idle after stop.
// - Idle ends when own slave address is seen on the bus.
// - Pin-write loads data bits 3..0 into latches of general-pin lines only.
// - Pin-read samples line levels into buffer; nothing returned in that message.
// - Sampled bits of non-general lines carry no defined meaning.
// - After reset all four lines are active-low slave-select outputs.
// - Each line is assigned to general or select use independently.
// - Pin-enable data bit 1 makes line general, 0 returns to select.
// - Newly enabled general lines start in quasi-bidirectional type.
// - Pin-config gives line n type bits 2n+1 and 2n.
// - Type 00 quasi, 01 push-pull, 10 input-only, 11 open-drain.
// - Quasi type enables very weak pull-up while latch holds 1.
// - Quasi weak pull-up only while latch and pin level are 1.
// - Quasi latch rising enables strong pull-up for two clocks.
// - Quasi latch 0 drives line low strongly.
// - Open-drain has no pull-ups, pulls down only while latch is 0.
// - Push-pull pulls up while latch 1, pulls down while latch 0.
module bridge_gpio_idle
#(
  parameter logic [6:0] SLAVE_ADDR = bridge_gpio_pkg::SLAVE_ADDR_DEF
) (
  input  wire logic                                    core_clk,
  input  wire logic                                    rst_n,
  input  wire logic                                    scl_i,
  input  wire logic                                    sda_i,
  output logic                                         sda_o,
  output logic                                         sda_oe,
  input  wire logic [bridge_gpio_pkg::NUM_LINES-1:0]   spi_select_n,
  input  wire logic [bridge_gpio_pkg::NUM_LINES-1:0]   select_line_i,
  output logic      [bridge_gpio_pkg::NUM_LINES-1:0]   select_line_o,
  output logic      [bridge_gpio_pkg::NUM_LINES-1:0]   select_line_oe,
  output logic      [bridge_gpio_pkg::NUM_LINES-1:0]   strong_pu_en,
  output logic      [bridge_gpio_pkg::NUM_LINES-1:0]   weak_pu_en,
  output logic      [bridge_gpio_pkg::NUM_LINES-1:0]   very_weak_pu_en,
  output logic                                         idle_mode
);
  import bridge_gpio_pkg::*;

  // ****************************************
  // Bus side state
  // ****************************************
  bus_state_e                state_q;
  logic [BYTE_BITS-1:0]      shift_q;
  logic [BYTE_BITS-1:0]      tx_q;
  logic [3:0]                cnt_q;
  logic                      rw_q;
  logic                      nack_q;
  logic [1:0]                byte_cnt_q;
  logic [BYTE_BITS-1:0]      func_q;
  logic [BYTE_BITS-1:0]      data_q;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_seen;
  logic                      stop_seen;
  logic                      addr_hit;

  // ****************************************
  // Command registers
  // ****************************************
  logic [NUM_LINES-1:0]      pin_output_latch_q;
  logic [NUM_LINES-1:0]      pin_function_select_q;
  logic [BYTE_BITS-1:0]      pin_output_type_q;
  logic [BYTE_BITS-1:0]      pin_state_sample_q;
  logic                      cmd_go;
  logic                      cmd_has_data;
  logic [NUM_LINES-1:0]      new_gp;

  function automatic logic func_is(input logic [7:0] code, input logic [7:0] want);
    func_is = (code == want);
  endfunction

  bus_edge_detect u_edges (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .scl_rise   (scl_rise),
    .scl_fall   (scl_fall),
    .start_seen (start_seen),
    .stop_seen  (stop_seen)
  );

  assign addr_hit = (state_q == BUS_ADDR) && scl_fall && (cnt_q == BIT_LAST)
                    && (shift_q[BYTE_BITS-1:1] == SLAVE_ADDR);

  // ****************************************
  // Slave byte engine
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q    <= BUS_IDLE;
      shift_q    <= 8'h00;
      tx_q       <= 8'h00;
      cnt_q      <= 4'h0;
      rw_q       <= 1'b0;
      nack_q     <= 1'b0;
      byte_cnt_q <= 2'h0;
      func_q     <= 8'h00;
      data_q     <= 8'h00;
      sda_oe     <= 1'b0;
    end else if (start_seen) begin
      state_q    <= BUS_ADDR;
      cnt_q      <= 4'h0;
      byte_cnt_q <= 2'h0;
      rw_q       <= 1'b0;
      sda_oe     <= 1'b0;
    end else if (stop_seen) begin
      state_q <= BUS_IDLE;
      sda_oe  <= 1'b0;
    end else begin
      case (state_q)
        BUS_ADDR: begin
          if (scl_rise) begin
            shift_q <= {shift_q[BYTE_BITS-2:0], sda_i};
            cnt_q   <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BIT_LAST) begin
            if (addr_hit) begin
              state_q <= BUS_ADDR_ACK;
              rw_q    <= shift_q[0];
              sda_oe  <= 1'b1;
            end else begin
              state_q <= BUS_IDLE;
            end
          end
        end
        BUS_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              // Buffer read needs no function code; buffer kept
              state_q <= BUS_RD_BYTE;
              tx_q    <= pin_state_sample_q;
              sda_oe  <= !pin_state_sample_q[BYTE_BITS-1];
            end else begin
              state_q <= BUS_WR_BYTE;
              sda_oe  <= 1'b0;
            end
          end
        end
        BUS_WR_BYTE: begin
          if (scl_rise) begin
            shift_q <= {shift_q[BYTE_BITS-2:0], sda_i};
            cnt_q   <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BIT_LAST) begin
            state_q <= BUS_WR_ACK;
            sda_oe  <= 1'b1;
            if (byte_cnt_q == 2'h0) begin
              func_q <= shift_q;
            end else if (byte_cnt_q == 2'h1) begin
              data_q <= shift_q;
            end
            if (byte_cnt_q != 2'h3) begin
              byte_cnt_q <= byte_cnt_q + 2'h1;
            end
          end
        end
        BUS_WR_ACK: begin
          if (scl_fall) begin
            state_q <= BUS_WR_BYTE;
            cnt_q   <= 4'h0;
            sda_oe  <= 1'b0;
          end
        end
        BUS_RD_BYTE: begin
          if (scl_fall) begin
            if (cnt_q == RD_LAST) begin
              state_q <= BUS_RD_ACK;
              sda_oe  <= 1'b0;
            end else begin
              tx_q   <= {tx_q[BYTE_BITS-2:0], 1'b0};
              sda_oe <= !tx_q[BYTE_BITS-2];
              cnt_q  <= cnt_q + 4'h1;
            end
          end
        end
        BUS_RD_ACK: begin
          if (scl_rise) begin
            nack_q <= sda_i;
          end else if (scl_fall) begin
            if (nack_q) begin
              state_q <= BUS_IDLE;
            end else begin
              // Further bytes repeat the buffered value
              state_q <= BUS_RD_BYTE;
              cnt_q   <= 4'h0;
              tx_q    <= pin_state_sample_q;
              sda_oe  <= !pin_state_sample_q[BYTE_BITS-1];
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Data line only ever pulled low
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ****************************************
  // Command completion at stop
  // ****************************************
  assign cmd_go       = stop_seen && !rw_q && (byte_cnt_q != 2'h0);
  assign cmd_has_data = byte_cnt_q > 2'h1;
  assign new_gp       = data_q[NUM_LINES-1:0] & ~pin_function_select_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      idle_mode <= 1'b0;
    end else if (addr_hit) begin
      idle_mode <= 1'b0;
    end else if (cmd_go && func_is(func_q, FUNC_IDLE)) begin
      idle_mode <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_output_latch_q <= LATCH_RESET;
    end else if (cmd_go && cmd_has_data && func_is(func_q, FUNC_PIN_WRITE)) begin
      pin_output_latch_q <= (pin_output_latch_q & ~pin_function_select_q)
                            | (data_q[NUM_LINES-1:0] & pin_function_select_q);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_function_select_q <= GP_EN_RESET;
    end else if (cmd_go && cmd_has_data && func_is(func_q, FUNC_PIN_ENABLE)) begin
      pin_function_select_q <= data_q[NUM_LINES-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_output_type_q <= TYPE_RESET;
    end else if (cmd_go && cmd_has_data && func_is(func_q, FUNC_PIN_CONFIG)) begin
      pin_output_type_q <= data_q;
    end else if (cmd_go && cmd_has_data && func_is(func_q, FUNC_PIN_ENABLE)) begin
      for (int n = 0; n < NUM_LINES; n++) begin
        if (new_gp[n]) begin
          pin_output_type_q[n*TYPE_BITS +: TYPE_BITS] <= TYPE_QUASI;
        end
      end
    end
  end

  // Levels of select-use lines are sampled too, meaning nothing
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_state_sample_q <= SAMPLE_RESET;
    end else if (cmd_go && func_is(func_q, FUNC_PIN_READ)) begin
      pin_state_sample_q <= {SAMPLE_PAD, select_line_i};
    end
  end

  // ****************************************
  // Per-line drivers
  // ****************************************
  for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
    select_pin_driver u_drv (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .gp_en        (pin_function_select_q[g]),
      .latch        (pin_output_latch_q[g]),
      .out_type     (pin_output_type_q[g*TYPE_BITS +: TYPE_BITS]),
      .pin_in       (select_line_i[g]),
      .select_n     (spi_select_n[g]),
      .pin_out      (select_line_o[g]),
      .pin_oe       (select_line_oe[g]),
      .strong_pu    (strong_pu_en[g]),
      .weak_pu      (weak_pu_en[g]),
      .very_weak_pu (very_weak_pu_en[g])
    );
  end

  // ****************************************
  // Checks
  // ****************************************
  a_idle_entry_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_go && func_q == FUNC_IDLE |=> idle_mode)
    else $error("idle not entered after idle command");
  a_idle_exit_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    addr_hit |=> !idle_mode)
    else $error("idle kept after own address");
  a_latch_masked_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_go && cmd_has_data && func_q == FUNC_PIN_WRITE
    |=> pin_output_latch_q == (($past(pin_output_latch_q) & ~$past(pin_function_select_q))
        | ($past(data_q[3:0]) & $past(pin_function_select_q))))
    else $error("latch write wrong");
  a_sample_no_reply: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_go && func_q == FUNC_PIN_READ |=> pin_state_sample_q[3:0] == $past(select_line_i)
    && state_q == BUS_IDLE)
    else $error("pin sample wrong");
  a_reset_select_use: assert property (@(posedge core_clk)
    !rst_n |=> pin_function_select_q == 4'h0 && pin_output_latch_q == 4'h0 ##1 select_line_oe == 4'hF)
    else $error("reset did not restore select use");
  a_enable_load_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_go && cmd_has_data && func_q == FUNC_PIN_ENABLE |=> pin_function_select_q == $past(data_q[3:0]))
    else $error("enable bits not loaded");
  a_enable_quasi_type: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_go && cmd_has_data && func_q == FUNC_PIN_ENABLE && new_gp[0] |=> pin_output_type_q[1:0] == TYPE_QUASI)
    else $error("new general line not quasi");
  a_config_load_type: assert property (@(posedge core_clk) disable iff (!rst_n)
    cmd_go && cmd_has_data && func_q == FUNC_PIN_CONFIG |=> pin_output_type_q == $past(data_q))
    else $error("type bits not loaded");
  a_select_use_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(rst_n) |-> ((select_line_o ^ $past(spi_select_n)) & ~$past(pin_function_select_q)) == 4'h0
    && (select_line_oe | $past(pin_function_select_q)) == 4'hF)
    else $error("select-use line not following its select");
  a_input_only_float: assert property (@(posedge core_clk) disable iff (!rst_n)
    pin_function_select_q[0] && pin_output_type_q[1:0] == TYPE_INPUT_ONLY
    |=> !select_line_oe[0] && !strong_pu_en[0] && !weak_pu_en[0] && !very_weak_pu_en[0])
    else $error("input-only line drives or pulls");
  a_quasi_very_weak: assert property (@(posedge core_clk) disable iff (!rst_n)
    pin_function_select_q[0] && pin_output_type_q[1:0] == TYPE_QUASI |=> very_weak_pu_en[0] == $past(pin_output_latch_q[0]))
    else $error("very weak pull-up does not follow latch");
  a_reset_clear_regs: assert property (@(posedge core_clk)
    !rst_n |=> pin_output_type_q == TYPE_RESET && pin_state_sample_q == SAMPLE_RESET && !idle_mode && !sda_oe)
    else $error("reset did not clear command state");
  a_lone_func_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    stop_seen && byte_cnt_q == 2'h1 |=> $stable(pin_output_latch_q) && $stable(pin_function_select_q)
    && $stable(pin_output_type_q))
    else $error("command without data byte changed pin state");
  a_read_keeps_buffer: assert property (@(posedge core_clk) disable iff (!rst_n)
    rw_q && state_q != BUS_IDLE |=> $stable(pin_state_sample_q))
    else $error("buffer changed during read");
  a_idle_only_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
    !idle_mode && !(cmd_go && func_q == FUNC_IDLE) |=> !idle_mode)
    else $error("idle entered without idle command");
endmodule
`default_nettype wire

// [sim/i2c_host_model.sv]
// Two-wire bus host model issuing command and buffer-read messages
`default_nettype none
module i2c_host_model
  import bridge_gpio_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // Start or repeated start, clock left low
  task automatic start();
    sda_low = 1'b0;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_low = 1'b1;
    wait_clk(4);
    scl = 1'b0;
  endtask
  // One byte plus ninth bit; data changes only while clock is low
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, input logic nine);
    for (int i = 8; i >= 0; i--) begin
      wait_clk(2);
      sda_low = (i == 0) ? ~nine : ~d[i-1];
      wait_clk(4);
      scl = 1'b1;
      wait_clk(4);
      if (i > 0) r[i-1] = sda;
      scl = 1'b0;
    end
  endtask
  task automatic stop();
    wait_clk(2);
    sda_low = 1'b1;
    wait_clk(4);
    scl = 1'b1;
    wait_clk(4);
    sda_low = 1'b0;
    wait_clk(4);
  endtask
  // Function code first, then data; abort ends with repeated start
  task automatic cmd(input logic [7:0] func, input logic [7:0] data, input logic with_data, input logic abort);
    logic [7:0] r;
    start();
    xfer({SLAVE_ADDR_DEF, 1'b0}, r, 1'b1);
    xfer(func, r, 1'b1);
    if (with_data) xfer(data, r, 1'b1);
    if (abort) begin
      start();
      xfer({SLAVE_ADDR_DEF, 1'b0}, r, 1'b1);
    end
    stop();
  endtask
  // One-byte buffer read, no function code, nack ends it
  task automatic rd_buf(output logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({SLAVE_ADDR_DEF, 1'b1}, r, 1'b1);
    xfer(8'hFF, d, 1'b1);
    stop();
  endtask
endmodule
`default_nettype wire

// [sim/bridge_gpio_idle_tb.sv]
// Self-checking bench for the pin and idle command block
`default_nettype none
module bridge_gpio_idle_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import bridge_gpio_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  spi_n = 4'hF;
  logic [3:0]  ext = 4'hF;
  logic [7:0]  d;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          spu_cnt = 0;
  logic [15:0] exp_q[$];
  logic [15:0] got_q[$];
  wire         scl, sda_low, sda_o, sda_oe, idle;
  wire [3:0]   lo, loe, spu, wpu, vwpu, lvl;
  wire         sda = ~(sda_low | sda_oe);
  assign lvl = (loe & lo) | (~loe & ext);
  always #20 core_clk = ~core_clk;
  i2c_host_model host_u (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  bridge_gpio_idle dut_u (.core_clk(core_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .spi_select_n(spi_n), .select_line_i(lvl), .select_line_o(lo), .select_line_oe(loe),
    .strong_pu_en(spu), .weak_pu_en(wpu), .very_weak_pu_en(vwpu), .idle_mode(idle));
  // ****************************************
  // Result watcher
  // ****************************************
  always @(negedge core_clk) begin
    while (got_q.size() > 0) begin
      total_checks++;
      if (got_q[0] !== exp_q[0]) begin
        failures++;
        $display("mismatch at %0t: expected %h got %h", $time, exp_q[0], got_q[0]);
      end
      got_q.delete(0);
      exp_q.delete(0);
    end
  end
  always @(posedge core_clk) begin
    if (spu[0] === 1'b1) spu_cnt++;
    cycles++;
    if (cycles == 30000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic note(input logic [15:0] g, input logic [15:0] e);
    got_q.push_back(g);
    exp_q.push_back(e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic tally_and_finish();
    @(negedge core_clk);
    #1;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    void'($urandom(32'h84b0ca0f));
    tick(2);
    rst_n = 1'b1;
    spi_n = 4'($urandom());
    tick(3);
    note({idle, sda_o, sda_oe, 1'b0, loe, lo, spu | wpu | vwpu}, {1'b0, 3'h0, 4'hF, spi_n, 4'h0});
    $display("test reset done");
    host_u.cmd(FUNC_PIN_ENABLE, 8'h05, 1'b1, 1'b0);
    tick(3);
    note({8'h0, loe, lo}, {8'h0, 4'hF, spi_n[3], 1'b0, spi_n[1], 1'b0});
    host_u.cmd(FUNC_PIN_WRITE, 8'h0F, 1'b1, 1'b1);
    tick(4);
    note({12'h0, loe & 4'h5}, 16'h5);
    ext = 4'hB;
    spu_cnt = 0;
    host_u.cmd(FUNC_PIN_WRITE, 8'h0F, 1'b1, 1'b0);
    tick(6);
    note(spu_cnt[15:0], 16'h2);
    note({vwpu, wpu, loe, lo & 4'hA}, {4'h5, 4'h1, 4'hA, spi_n[3], 1'b0, spi_n[1], 1'b0});
    $display("test quasi done");
    host_u.cmd(FUNC_PIN_CONFIG, 8'h31, 1'b1, 1'b0);
    tick(3);
    note({spu, wpu | vwpu, loe, 3'h0, lo[0]}, {4'h1, 4'h0, 4'hB, 4'h1});
    host_u.cmd(FUNC_PIN_WRITE, 8'h00, 1'b1, 1'b0);
    tick(3);
    note({spu, wpu | vwpu, loe, lo & 4'h5}, {8'h0, 4'hF, 4'h0});
    host_u.cmd(FUNC_PIN_CONFIG, 8'h22, 1'b1, 1'b0);
    tick(3);
    note({4'h0, spu | wpu | vwpu, loe, 4'h0}, {8'h0, 4'hA, 4'h0});
    $display("test types done");
    for (int i = 0; i < 3; i++) begin
      ext = 4'($urandom());
      host_u.cmd(FUNC_PIN_READ, 8'h00, 1'b0, 1'b0);
      ext = ~ext;
      host_u.rd_buf(d);
      note({8'h0, d & 8'h05}, {12'h0, ~ext & 4'h5});
    end
    $display("test sample done");
    host_u.cmd(FUNC_IDLE, 8'h00, 1'b0, 1'b0);
    tick(2);
    note({15'h0, idle}, 16'h1);
    host_u.rd_buf(d);
    note({15'h0, idle}, 16'h0);
    host_u.cmd(FUNC_PIN_ENABLE, 8'h00, 1'b1, 1'b0);
    tick(3);
    note({8'h0, loe, lo}, {8'h0, 4'hF, spi_n});
    host_u.cmd(FUNC_PIN_ENABLE, 8'h05, 1'b1, 1'b0);
    tick(3);
    note({12'h0, loe & 4'h5}, 16'h5);
    $display("test idle done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
